/* hw/fprfc_defs.svh */
// Constants of the 82-bit register word and of the memory formats
`ifndef FPRFC_DEFS_SVH
`define FPRFC_DEFS_SVH
`define FPRFC_WORD_W    82
`define FPRFC_EXP_W     17
`define FPRFC_SIG_W     64
`define FPRFC_MEM_W     80
`define FPRFC_SIGN_POS  81
`define FPRFC_EXP_HI    80
`define FPRFC_EXP_LO    64
`define FPRFC_INT_POS   63
`define FPRFC_QUIET_POS 62
`define FPRFC_BIAS      17'h0ffff
`define FPRFC_EXP_ALL1  17'h1ffff
`define FPRFC_EXP_ZERO  17'h00000
`define FPRFC_NRM_EMIN  17'h00001
`define FPRFC_NRM_EMAX  17'h1fffe
`define FPRFC_EXP_INT   17'h1003e
`define FPRFC_SGL_EMIN  17'h0ff81
`define FPRFC_SGL_EMAX  17'h1007e
`define FPRFC_DBL_EMIN  17'h0fc01
`define FPRFC_DBL_EMAX  17'h103fe
`define FPRFC_EXT_EMIN  17'h0c001
`define FPRFC_EXT_EMAX  17'h13ffe
`define FPRFC_SGL_OFF   17'h0ff80
`define FPRFC_DBL_OFF   17'h0fc00
`define FPRFC_EXT_OFF   17'h0c000
`define FPRFC_DEN_UNB   18'h3c002
`define FPRFC_SGL_LOW   40
`define FPRFC_DBL_LOW   11
`define FPRFC_SGL_EW    8
`define FPRFC_DBL_EW    11
`define FPRFC_EXT_EW    15
`define FPRFC_SGL_FW    23
`define FPRFC_DBL_FW    52
`endif

/* hw/fprfc_pkg.sv */
// Types shared by the register format classifier
`default_nettype none
`include "fprfc_defs.svh"
package fprfc_pkg;
  typedef enum {CLS_ZERO, CLS_INF, CLS_QNAN, CLS_SNAN, CLS_NORMAL,
                CLS_UNNORM, CLS_DENORM, CLS_PDENORM, CLS_UNSUP, CLS_COUNT} fprfc_cls_e;
  typedef logic [CLS_COUNT-1:0] fprfc_cls_t;
  typedef logic [`FPRFC_WORD_W-1:0] fprfc_word_t;
  typedef enum logic [2:0] {SRC_WORD, SRC_MEM, SRC_INT, SRC_CZERO, SRC_CONE} fprfc_src_e;
  typedef enum logic [1:0] {FMT_SGL, FMT_DBL, FMT_EXT} fprfc_fmt_e;
  typedef enum logic {PCM_EXT_RANGE, PCM_DEST} fprfc_pcm_e;
endpackage : fprfc_pkg
`default_nettype wire

/* hw/fprfc_classify.sv */
// Combinational one-hot classifier of a register word
`default_nettype none
`include "fprfc_defs.svh"
module fprfc_classify (
  input  wire fprfc_pkg::fprfc_word_t word_in,
  output fprfc_pkg::fprfc_cls_t       class_out,
  output logic [17:0]                 unb_exp_out
);
  wire [16:0] exp_f  = word_in[`FPRFC_EXP_HI:`FPRFC_EXP_LO];
  wire        int_b  = word_in[`FPRFC_INT_POS];
  wire        frac_nz = |word_in[`FPRFC_INT_POS-1:0];
  wire        e_zero = (exp_f == `FPRFC_EXP_ZERO);
  wire        e_all1 = (exp_f == `FPRFC_EXP_ALL1);
  wire        e_mid  = !e_zero && !e_all1;
  wire        quiet  = word_in[`FPRFC_QUIET_POS];

  assign class_out[fprfc_pkg::CLS_ZERO]    = e_zero && !int_b && !frac_nz;
  assign class_out[fprfc_pkg::CLS_DENORM]  = e_zero && !int_b && frac_nz;
  assign class_out[fprfc_pkg::CLS_PDENORM] = e_zero && int_b;
  assign class_out[fprfc_pkg::CLS_INF]     = e_all1 && int_b && !frac_nz;
  assign class_out[fprfc_pkg::CLS_QNAN]    = e_all1 && int_b && quiet;
  assign class_out[fprfc_pkg::CLS_SNAN]    = e_all1 && int_b && !quiet && frac_nz;
  assign class_out[fprfc_pkg::CLS_UNSUP]   = e_all1 && !int_b;
  assign class_out[fprfc_pkg::CLS_NORMAL]  = e_mid && int_b;
  // Pseudo-zeros land here too, never in the zero class
  assign class_out[fprfc_pkg::CLS_UNNORM]  = e_mid && !int_b;

  // Zero exponent field scales as the smallest extended normal exponent, 0x0C001
  assign unb_exp_out = e_zero ? `FPRFC_DEN_UNB
                              : ({1'b0, exp_f} - {1'b0, `FPRFC_BIAS});
endmodule : fprfc_classify
`default_nettype wire

/* hw/fprfc_mem_convert.sv */
// Memory format to register format conversion
`default_nettype none
`include "fprfc_defs.svh"
module fprfc_mem_convert (
  input  wire fprfc_pkg::fprfc_fmt_e   fmt_in,
  input  wire logic [`FPRFC_MEM_W-1:0] mem_in,
  output fprfc_pkg::fprfc_word_t       word_out
);
  // Single: 1 sign, 8 exponent, 23 fraction, hidden integer bit
  wire [7:0]  s_exp  = mem_in[30:23];
  wire [22:0] s_frac = mem_in[22:0];
  wire [16:0] s_rexp = (s_exp == 8'hff) ? `FPRFC_EXP_ALL1 :
                       (s_exp == 8'h00) ? ((s_frac == 23'h0) ? `FPRFC_EXP_ZERO : `FPRFC_SGL_EMIN) :
                       ({9'h0, s_exp} + `FPRFC_SGL_OFF);
  wire        s_int  = (s_exp != 8'h00);
  wire fprfc_pkg::fprfc_word_t s_word = {mem_in[31], s_rexp, s_int, s_frac, 40'h0};

  // Double: 1 sign, 11 exponent, 52 fraction, hidden integer bit
  wire [10:0] d_exp  = mem_in[62:52];
  wire [51:0] d_frac = mem_in[51:0];
  wire [16:0] d_rexp = (d_exp == 11'h7ff) ? `FPRFC_EXP_ALL1 :
                       (d_exp == 11'h000) ? ((d_frac == 52'h0) ? `FPRFC_EXP_ZERO : `FPRFC_DBL_EMIN) :
                       ({6'h0, d_exp} + `FPRFC_DBL_OFF);
  wire        d_int  = (d_exp != 11'h000);
  wire fprfc_pkg::fprfc_word_t d_word = {mem_in[63], d_rexp, d_int, d_frac, 11'h0};

  // Double-extended: explicit integer bit; denormals keep the zero exponent
  wire [14:0] x_exp  = mem_in[78:64];
  wire [16:0] x_rexp = (x_exp == 15'h7fff) ? `FPRFC_EXP_ALL1 :
                       (x_exp == 15'h0000) ? `FPRFC_EXP_ZERO :
                       ({2'h0, x_exp} + `FPRFC_EXT_OFF);
  wire fprfc_pkg::fprfc_word_t x_word = {mem_in[79], x_rexp, mem_in[63:0]};

  assign word_out = (fmt_in == fprfc_pkg::FMT_SGL) ? s_word :
                    (fmt_in == fprfc_pkg::FMT_DBL) ? d_word : x_word;
endmodule : fprfc_mem_convert
`default_nettype wire

/* hw/fprfc_top.sv */
// Register format classifier: source select, classification, range checks
// Function
// - Word is 82 bits: sign at top, 17-bit exponent, 64-bit significand.
// - Significand bit 63 is the explicit integer bit, 62:0 the fraction.
// - Exponent field carries a bias of 65535.
// - All-ones exponent: infinity with zero fraction, NaN with nonzero fraction.
// - Zero exponent and zero significand is a signed zero.
// - Zero exponent, nonzero significand: denormal, or pseudo-denormal with integer bit.
// - Sign zero means positive, sign one means negative.
// - Nonzero exponent scales by two to exponent minus 65535.
// - Zero exponent scales by two to minus 16382.
// - Integers fill the significand; canonical exponent 0x1003E, sign zero.
// - Exponent 0x00001 to 0x1FFFE with integer bit set is normal.
// - Integer bit clear with in-range exponent, even with zero significand, is unnormal.
// - Single normals: exponent 0x0FF81..0x1007E, integer bit, low 40 bits zero.
// - Double normals: exponent 0x0FC01..0x103FE, integer bit, low 11 bits zero.
// - Extended normals: exponent 0x0C001..0x13FFE with integer bit.
// - Stack single/double results use extended range, narrower significand.
// - Large integers: sign 0, exponent 0x1003E; zero fraction is integer indefinite.
// - Memory exponents are 8, 11, 15 bits; widths 32, 64, 80.
// - Memory significands are 23, 52, 64 bits; integer bit explicit only in extended.
// - Precision control: round to extended range or to destination format.
// - Exponent 0x0C001 with integer bit equals the matching pseudo-denormal.
// - Constant-one register never changes with instruction type.
// - All-ones exponent with integer bit clear is unsupported, never a result.
// - Constant-zero reads all zero; constant-one reads exponent 0x0FFFF, integer bit.
// - Extended denormal results use exponent zero, not 0x0C001.
`default_nettype none
`include "fprfc_defs.svh"
module fprfc_top (
  input  wire logic                    clk_in,
  input  wire logic                    rstn_in,
  input  wire logic                    valid_in,
  input  wire fprfc_pkg::fprfc_src_e   src_in,
  input  wire fprfc_pkg::fprfc_word_t  word_in,
  input  wire fprfc_pkg::fprfc_fmt_e   fmt_in,
  input  wire logic [`FPRFC_MEM_W-1:0] mem_in,
  input  wire logic [63:0]             int_in,
  input  wire fprfc_pkg::fprfc_pcm_e   pcm_in,
  output logic                         valid_out,
  output fprfc_pkg::fprfc_word_t       word_out,
  output logic                         neg_out,
  output logic [16:0]                  exp_out,
  output logic [63:0]                  sig_out,
  output fprfc_pkg::fprfc_cls_t        class_out,
  output logic [17:0]                  unb_exp_out,
  output logic                         fits_out,
  output logic                         canon_int_out,
  output logic                         int_indef_out,
  output logic                         pden_equiv_out,
  output logic                         result_ok_out
);
  function automatic logic in_rng(input logic [16:0] e, input logic [16:0] lo, input logic [16:0] hi);
    in_rng = (e >= lo) && (e <= hi);
  endfunction : in_rng

  localparam fprfc_pkg::fprfc_word_t ONE_WORD = {1'b0, `FPRFC_BIAS, 1'b1, 63'h0};

  fprfc_pkg::fprfc_word_t mem_word;
  fprfc_pkg::fprfc_word_t next_word;
  fprfc_pkg::fprfc_cls_t  next_class;
  logic [17:0]            next_unb;

  fprfc_mem_convert u_conv (
    .fmt_in   (fmt_in),
    .mem_in   (mem_in),
    .word_out (mem_word)
  );

  // Constants ignore every other input so the one register cannot drift
  assign next_word = (src_in == fprfc_pkg::SRC_CZERO) ? '0 :
                     (src_in == fprfc_pkg::SRC_CONE)  ? ONE_WORD :
                     (src_in == fprfc_pkg::SRC_MEM)   ? mem_word :
                     (src_in == fprfc_pkg::SRC_INT)   ? {1'b0, `FPRFC_EXP_INT, int_in} :
                     word_in;

  fprfc_classify u_cls (
    .word_in     (next_word),
    .class_out   (next_class),
    .unb_exp_out (next_unb)
  );

  // Field split of the candidate word
  wire        n_sign = next_word[`FPRFC_SIGN_POS];
  wire [16:0] n_exp  = next_word[`FPRFC_EXP_HI:`FPRFC_EXP_LO];
  wire [63:0] n_sig  = next_word[`FPRFC_SIG_W-1:0];
  wire        n_int  = n_sig[`FPRFC_INT_POS];
  wire        n_fz   = (n_sig[`FPRFC_INT_POS-1:0] == 63'h0);
  wire        n_l40  = (n_sig[`FPRFC_SGL_LOW-1:0] == 40'h0);
  wire        n_l11  = (n_sig[`FPRFC_DBL_LOW-1:0] == 11'h0);

  // Format range checks
  wire sgl_ok = in_rng(n_exp, `FPRFC_SGL_EMIN, `FPRFC_SGL_EMAX) && n_int && n_l40;
  wire dbl_ok = in_rng(n_exp, `FPRFC_DBL_EMIN, `FPRFC_DBL_EMAX) && n_int && n_l11;
  wire ext_rg = in_rng(n_exp, `FPRFC_EXT_EMIN, `FPRFC_EXT_EMAX) && n_int;
  wire ext_ok = ext_rg;
  wire stk_sgl = ext_rg && n_l40;
  wire stk_dbl = ext_rg && n_l11;

  // Extended-range method keeps the wide exponent but narrows the significand
  wire fit_ext = (fmt_in == fprfc_pkg::FMT_SGL) ? stk_sgl :
                 (fmt_in == fprfc_pkg::FMT_DBL) ? stk_dbl : ext_ok;
  wire fit_dst = (fmt_in == fprfc_pkg::FMT_SGL) ? sgl_ok :
                 (fmt_in == fprfc_pkg::FMT_DBL) ? dbl_ok : ext_ok;
  wire next_fits = (pcm_in == fprfc_pkg::PCM_DEST) ? fit_dst : fit_ext;

  wire next_canon = !n_sign && (n_exp == `FPRFC_EXP_INT);
  wire next_indef = next_canon && n_int && n_fz;
  wire next_pdeq  = (n_exp == `FPRFC_EXT_EMIN) && n_int;

  // Encodings an arithmetic unit must never write back
  wire pzero      = next_class[fprfc_pkg::CLS_UNNORM] && !n_int && n_fz;
  wire ext_den_hi = (n_exp == `FPRFC_EXT_EMIN) && !n_int;
  wire next_rok   = !next_class[fprfc_pkg::CLS_UNSUP]
                    && !next_class[fprfc_pkg::CLS_PDENORM]
                    && !pzero
                    && !ext_den_hi;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      valid_out <= 1'b0;
    end else begin
      valid_out <= valid_in;
    end
  end

  // Data stage loads only on valid to save toggling
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      word_out       <= '0;
      neg_out        <= 1'b0;
      exp_out        <= 17'h0;
      sig_out        <= 64'h0;
      class_out      <= '0;
      unb_exp_out    <= 18'h0;
      fits_out       <= 1'b0;
      canon_int_out  <= 1'b0;
      int_indef_out  <= 1'b0;
      pden_equiv_out <= 1'b0;
      result_ok_out  <= 1'b0;
    end else if (valid_in) begin
      word_out       <= next_word;
      neg_out        <= n_sign;
      exp_out        <= n_exp;
      sig_out        <= n_sig;
      class_out      <= next_class;
      unb_exp_out    <= next_unb;
      fits_out       <= next_fits;
      canon_int_out  <= next_canon;
      int_indef_out  <= next_indef;
      pden_equiv_out <= next_pdeq;
      result_ok_out  <= next_rok;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  a_fields_split: assert property (valid_out |-> word_out == {neg_out, exp_out, sig_out})
    else $error("word fields do not match the packed word");
  a_class_onehot: assert property (valid_out |-> $onehot(class_out))
    else $error("class vector is not one-hot");
  a_zero_class: assert property (valid_in && src_in == fprfc_pkg::SRC_CZERO |=>
      word_out == '0 && class_out[fprfc_pkg::CLS_ZERO] && !neg_out)
    else $error("constant zero register read wrong");
  a_one_fixed: assert property (valid_in && src_in == fprfc_pkg::SRC_CONE |=>
      exp_out == `FPRFC_BIAS && sig_out == 64'h8000000000000000 && unb_exp_out == 18'h0)
    else $error("constant one register read wrong");
  a_int_canon: assert property (valid_in && src_in == fprfc_pkg::SRC_INT |=>
      canon_int_out && sig_out == $past(int_in) && int_indef_out == (sig_out == 64'h8000000000000000))
    else $error("integer not in canonical form");
  a_unb_exp: assert property (valid_out && exp_out != 17'h0 |->
      unb_exp_out == ({1'b0, exp_out} - 18'h0ffff))
    else $error("unbiased exponent wrong");
  a_den_scale: assert property (valid_out && exp_out == 17'h0 |-> unb_exp_out == 18'h3c002)
    else $error("zero exponent scale wrong");
  a_nan_enc: assert property (valid_out && (class_out[fprfc_pkg::CLS_QNAN] ||
      class_out[fprfc_pkg::CLS_SNAN]) |-> exp_out == 17'h1ffff && sig_out[63] && sig_out[62:0] != 63'h0)
    else $error("NaN class with wrong encoding");
  a_unsup_res: assert property (valid_out && class_out[fprfc_pkg::CLS_UNSUP] |-> !result_ok_out)
    else $error("unsupported encoding allowed as result");
  a_sgl_load: assert property (valid_in && src_in == fprfc_pkg::SRC_MEM && fmt_in == fprfc_pkg::FMT_SGL
      && mem_in[30:23] != 8'h00 && mem_in[30:23] != 8'hff |=>
      exp_out == ({9'h0, $past(mem_in[30:23])} + 17'h0ff80) && sig_out[63] && sig_out[39:0] == 40'h0)
    else $error("single load conversion wrong");
  a_pden_equiv: assert property (valid_out && exp_out == 17'h0c001 && sig_out[63] |->
      pden_equiv_out && class_out[fprfc_pkg::CLS_NORMAL])
    else $error("pseudo-denormal equivalent not flagged");
  a_hold_idle: assert property (!valid_in |=> $stable(word_out))
    else $error("word changed without a request");

  c_qnan_seen: cover property (valid_out && class_out[fprfc_pkg::CLS_QNAN]);
  c_dbl_fit:   cover property (valid_out && fits_out && $past(fmt_in) == fprfc_pkg::FMT_DBL);
  c_pdenorm:   cover property (valid_out && class_out[fprfc_pkg::CLS_PDENORM]);
  c_back2back: cover property (valid_in ##1 valid_in ##1 valid_out);
endmodule : fprfc_top
`default_nettype wire

/* tb/fprfc_top_tb.sv */
// Self-checking bench of the register format classifier
`default_nettype none
module fprfc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  clk_in;
  logic                  rstn_in;
  logic                  valid_in;
  fprfc_pkg::fprfc_src_e src_in;
  fprfc_pkg::fprfc_word_t word_in;
  fprfc_pkg::fprfc_fmt_e fmt_in;
  logic [79:0]           mem_in;
  logic [63:0]           int_in;
  fprfc_pkg::fprfc_pcm_e pcm_in;
  logic                  valid_out;
  fprfc_pkg::fprfc_word_t word_out;
  logic                  neg_out;
  logic [16:0]           exp_out;
  logic [63:0]           sig_out;
  fprfc_pkg::fprfc_cls_t class_out;
  logic [17:0]           unb_exp_out;
  logic                  fits_out;
  logic                  canon_int_out;
  logic                  int_indef_out;
  logic                  pden_equiv_out;
  logic                  result_ok_out;
  int                    fail_count;
  int                    checked;
  localparam logic [63:0] ONE = 64'h8000000000000000;

  fprfc_top dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .valid_in(valid_in), .src_in(src_in),
    .word_in(word_in), .fmt_in(fmt_in), .mem_in(mem_in), .int_in(int_in), .pcm_in(pcm_in),
    .valid_out(valid_out), .word_out(word_out), .neg_out(neg_out), .exp_out(exp_out),
    .sig_out(sig_out), .class_out(class_out), .unb_exp_out(unb_exp_out), .fits_out(fits_out),
    .canon_int_out(canon_int_out), .int_indef_out(int_indef_out),
    .pden_equiv_out(pden_equiv_out), .result_ok_out(result_ok_out));

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  function automatic fprfc_pkg::fprfc_word_t wd(input logic s, input logic [16:0] e, input logic [63:0] g);
    return {s, e, g};
  endfunction : wd

  function automatic fprfc_pkg::fprfc_cls_t cb(input fprfc_pkg::fprfc_cls_e c);
    return fprfc_pkg::fprfc_cls_t'(1) << c;
  endfunction : cb

  task automatic check(input string name, input logic [81:0] seen, input logic [81:0] expv);
    checked++;
    if (seen !== expv) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, expv, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  // Inputs are set 10 ns after an edge; results are judged 10 ns after the taking edge
  task automatic go();
    valid_in = 1'b1;
    @(posedge clk_in);
    #10 valid_in = 1'b0;
    check("valid_out", valid_out, 1'b1);
  endtask : go

  task automatic send_word(input fprfc_pkg::fprfc_word_t w);
    src_in = fprfc_pkg::SRC_WORD;
    word_in = w;
    go();
  endtask : send_word

  task automatic cls_case(input fprfc_pkg::fprfc_word_t w, input fprfc_pkg::fprfc_cls_e c, input logic ok);
    send_word(w);
    check("class_out", class_out, cb(c));
    check("result_ok_out", result_ok_out, ok);
  endtask : cls_case

  task automatic test_constants();
    src_in = fprfc_pkg::SRC_CZERO;
    go();
    check("czero word", word_out, 82'h0);
    check("czero class", class_out, cb(fprfc_pkg::CLS_ZERO));
    src_in = fprfc_pkg::SRC_CONE;
    int_in = 64'hffffffffffffffff;
    go();
    check("cone word", word_out, wd(1'b0, 17'h0ffff, ONE));
    check("cone unb", unb_exp_out, 18'h00000);
  endtask : test_constants

  task automatic test_fields();
    send_word(wd(1'b1, 17'h12345, 64'h0123456789abcdef));
    check("neg_out", neg_out, 1'b1);
    check("exp_out", exp_out, 17'h12345);
    check("sig_out", sig_out, 64'h0123456789abcdef);
    check("word_out", word_out, wd(1'b1, 17'h12345, 64'h0123456789abcdef));
    send_word(wd(1'b0, 17'h00001, ONE));
    check("neg_out pos", neg_out, 1'b0);
    check("unb min", unb_exp_out, 18'h30002);
    send_word(wd(1'b0, 17'h10000, ONE));
    check("unb plus one", unb_exp_out, 18'h00001);
    send_word(wd(1'b1, 17'h00000, 64'h1));
    check("unb zero exp", unb_exp_out, 18'h3c002);
  endtask : test_fields

  task automatic test_classes();
    cls_case(wd(1'b1, 17'h00000, 64'h0), fprfc_pkg::CLS_ZERO, 1'b1);
    cls_case(wd(1'b1, 17'h1ffff, ONE), fprfc_pkg::CLS_INF, 1'b1);
    cls_case(wd(1'b0, 17'h1ffff, 64'hc000000000000000), fprfc_pkg::CLS_QNAN, 1'b1);
    cls_case(wd(1'b0, 17'h1ffff, 64'h8000000000000001), fprfc_pkg::CLS_SNAN, 1'b1);
    cls_case(wd(1'b0, 17'h1ffff, 64'h4000000000000000), fprfc_pkg::CLS_UNSUP, 1'b0);
    cls_case(wd(1'b1, 17'h1ffff, 64'h0), fprfc_pkg::CLS_UNSUP, 1'b0);
    cls_case(wd(1'b0, 17'h00001, ONE), fprfc_pkg::CLS_NORMAL, 1'b1);
    cls_case(wd(1'b1, 17'h1fffe, 64'hffffffffffffffff), fprfc_pkg::CLS_NORMAL, 1'b1);
    cls_case(wd(1'b0, 17'h1fffe, 64'h7fffffffffffffff), fprfc_pkg::CLS_UNNORM, 1'b1);
    cls_case(wd(1'b0, 17'h1fffd, 64'h0), fprfc_pkg::CLS_UNNORM, 1'b0);
    cls_case(wd(1'b0, 17'h00000, 64'h7fffffffffffffff), fprfc_pkg::CLS_DENORM, 1'b1);
    cls_case(wd(1'b1, 17'h00000, ONE), fprfc_pkg::CLS_PDENORM, 1'b0);
    cls_case(wd(1'b0, 17'h0c001, ONE), fprfc_pkg::CLS_NORMAL, 1'b1);
    check("pden_equiv set", pden_equiv_out, 1'b1);
    cls_case(wd(1'b0, 17'h0c001, 64'h1), fprfc_pkg::CLS_UNNORM, 1'b0);
    check("pden_equiv clear", pden_equiv_out, 1'b0);
  endtask : test_classes

  task automatic test_integer();
    src_in = fprfc_pkg::SRC_INT;
    int_in = ONE;
    go();
    check("int word", word_out, wd(1'b0, 17'h1003e, ONE));
    check("int indef", int_indef_out, 1'b1);
    check("int canon", canon_int_out, 1'b1);
    int_in = 64'h5;
    go();
    check("small int word", word_out, wd(1'b0, 17'h1003e, 64'h5));
    check("small int indef", int_indef_out, 1'b0);
    send_word(wd(1'b1, 17'h1003e, ONE));
    check("signed canon", canon_int_out, 1'b0);
  endtask : test_integer

  // Each range is probed at some of its ends, from inside or just outside, under both methods
  task automatic fit_case(input fprfc_pkg::fprfc_fmt_e f, input logic [16:0] e, input logic [63:0] g,
                          input logic fit_ext, input logic fit_dest);
    fmt_in = f;
    pcm_in = fprfc_pkg::PCM_EXT_RANGE;
    send_word(wd(1'b0, e, g));
    check("fits ext range", fits_out, fit_ext);
    pcm_in = fprfc_pkg::PCM_DEST;
    send_word(wd(1'b1, e, g));
    check("fits dest", fits_out, fit_dest);
  endtask : fit_case

  task automatic test_fits();
    fit_case(fprfc_pkg::FMT_SGL, 17'h0ff81, 64'hffffff0000000000, 1'b1, 1'b1);
    fit_case(fprfc_pkg::FMT_SGL, 17'h0ff80, ONE, 1'b1, 1'b0);
    fit_case(fprfc_pkg::FMT_SGL, 17'h1007f, ONE, 1'b1, 1'b0);
    fit_case(fprfc_pkg::FMT_SGL, 17'h10000, 64'h8000008000000000, 1'b0, 1'b0);
    fit_case(fprfc_pkg::FMT_DBL, 17'h103fe, 64'hfffffffffffff800, 1'b1, 1'b1);
    fit_case(fprfc_pkg::FMT_DBL, 17'h0fc00, ONE, 1'b1, 1'b0);
    fit_case(fprfc_pkg::FMT_DBL, 17'h10000, 64'h8000000000000400, 1'b0, 1'b0);
    fit_case(fprfc_pkg::FMT_EXT, 17'h0c001, 64'hffffffffffffffff, 1'b1, 1'b1);
    fit_case(fprfc_pkg::FMT_EXT, 17'h13fff, ONE, 1'b0, 1'b0);
    fit_case(fprfc_pkg::FMT_EXT, 17'h10000, 64'h7fffffffffffffff, 1'b0, 1'b0);
  endtask : test_fits

  task automatic mem_case(input fprfc_pkg::fprfc_fmt_e f, input logic [79:0] m, input fprfc_pkg::fprfc_word_t w);
    src_in = fprfc_pkg::SRC_MEM;
    fmt_in = f;
    mem_in = m;
    go();
    check("mem word", word_out, w);
  endtask : mem_case

  task automatic test_memory();
    mem_case(fprfc_pkg::FMT_SGL, 80'h3f800000, wd(1'b0, 17'h0ffff, ONE));
    mem_case(fprfc_pkg::FMT_SGL, 80'hc0400001, wd(1'b1, 17'h10000, 64'hc000010000000000));
    mem_case(fprfc_pkg::FMT_DBL, 80'h3ff0000000000001, wd(1'b0, 17'h0ffff, 64'h8000000000000800));
    mem_case(fprfc_pkg::FMT_EXT, 80'hbfff_c000000000000001, wd(1'b1, 17'h0ffff, 64'hc000000000000001));
    mem_case(fprfc_pkg::FMT_SGL, 80'h7f800000, wd(1'b0, 17'h1ffff, ONE));
    check("mem inf class", class_out, cb(fprfc_pkg::CLS_INF));
  endtask : test_memory

  // With no request the registered answer must not move
  task automatic test_hold();
    send_word(wd(1'b1, 17'h0c001, ONE));
    word_in = 82'h0;
    src_in = fprfc_pkg::SRC_CONE;
    @(posedge clk_in);
    #10 check("hold valid", valid_out, 1'b0);
    check("hold word", word_out, wd(1'b1, 17'h0c001, ONE));
  endtask : test_hold

  initial begin
    fail_count = 0;
    checked = 0;
    rstn_in = 1'b0;
    valid_in = 1'b0;
    src_in = fprfc_pkg::SRC_WORD;
    word_in = 82'h0;
    fmt_in = fprfc_pkg::FMT_SGL;
    mem_in = 80'h0;
    int_in = 64'h0;
    pcm_in = fprfc_pkg::PCM_EXT_RANGE;
    repeat (12) @(posedge clk_in);
    #10 rstn_in = 1'b1;
    check("reset word", word_out, 82'h0);
    check("reset valid", valid_out, 1'b0);
    test_constants();
    test_fields();
    test_classes();
    test_integer();
    test_fits();
    test_memory();
    test_hold();
    stop_test();
  end

  // 49 requests are made; the limit leaves ample margin
  initial begin
    #(100 * 2000);
    fail_count++;
    stop_test();
  end
endmodule : fprfc_top_tb
`default_nettype wire
